/* File: verilog/fes_pkg.sv */
// Purpose: Constants for the flash erase suspend sequencer host
// Assumes: 100 MHz clock, byte-wide parallel flash bus
// Notes:   Commands, status bits and pin timing counts
package fes_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0]  CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0]  CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
  localparam int unsigned STATUS_READY_BIT     = 7;
  localparam int unsigned STATUS_SUSPENDED_BIT = 6;
  localparam int unsigned ADDR_W         = 17;
  localparam int unsigned CE_LOW_NS      = 40;
  localparam int unsigned CE_HIGH_NS     = 40;
  localparam int unsigned RELOCK_NS      = 100;
  localparam int unsigned CE_LOW_CYC     = (CE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CE_HIGH_CYC    = (CE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RELOCK_CYC     = (RELOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W          = 4;
endpackage : fes_pkg

/* File: verilog/fes_bus_if.sv */
// Purpose: Carrier between sequencer and its pin cycle engine
// Assumes: One clock domain
// Notes:   req/done handshake for one pin cycle
`timescale 1ns/1ps
interface fes_bus_if;
  logic        req;
  logic        wr;
  logic [16:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        done;
  modport seq (output req, output wr, output addr, output wdata,
               input rdata, input done);
  modport eng (input req, input wr, input addr, input wdata,
               output rdata, output done);
endinterface : fes_bus_if

/* File: verilog/fes_cycle_engine.sv */
// Purpose: One chip-select controlled write or read cycle on the flash pins
// Assumes: Write strobe held low for writes, chip select pulses
// Notes:   Read data sampled through two flip-flops before use
`timescale 1ns/1ps
module fes_cycle_engine
  import fes_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  fes_bus_if.eng           bus,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [16:0]      addr,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_in
);
  typedef enum logic [3:0] {
    E_IDLE = 4'b0001, E_LOW = 4'b0010, E_HIGH = 4'b0100, E_DONE = 4'b1000
  } fes_eng_t;
  fes_eng_t          st_ff, nxt_st;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic              wr_ff, nxt_wr;
  logic [16:0]       addr_ff, nxt_addr;
  logic [7:0]        wd_ff, nxt_wd;
  logic [7:0]        s1_ff, s2_ff, rd_ff, nxt_rd;

  // ----------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff; nxt_cnt = cnt_ff; nxt_wr = wr_ff;
    nxt_addr = addr_ff; nxt_wd = wd_ff; nxt_rd = rd_ff;
    case (st_ff)
      E_IDLE: if (bus.req) begin
        nxt_wr = bus.wr; nxt_addr = bus.addr; nxt_wd = bus.wdata;
        nxt_cnt = '0; nxt_st = E_LOW;
      end
      E_LOW: begin
        nxt_cnt = cnt_ff + 1'b1;
        // Extra two cycles cover the read synchroniser
        if (cnt_ff == CNT_W'(CE_LOW_CYC + 2)) begin
          nxt_rd = s2_ff; nxt_cnt = '0; nxt_st = E_HIGH; // RL9
        end
      end
      E_HIGH: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == CNT_W'(CE_HIGH_CYC)) nxt_st = E_DONE;
      end
      E_DONE: nxt_st = E_IDLE;
      default: nxt_st = E_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= E_IDLE; cnt_ff <= '0; wr_ff <= 1'b0;
      addr_ff <= '0; wd_ff <= '0; rd_ff <= '0; s1_ff <= '0; s2_ff <= '0;
    end else begin
      st_ff <= nxt_st; cnt_ff <= nxt_cnt; wr_ff <= nxt_wr;
      addr_ff <= nxt_addr; wd_ff <= nxt_wd; rd_ff <= nxt_rd;
      s1_ff <= dq_in; s2_ff <= s1_ff;
    end
  end

  // Chip select pulse; address and data held through its rising edge
  assign ce_n      = (st_ff != E_LOW); // RL9
  assign we_n      = !wr_ff || (st_ff == E_IDLE); // RL9
  assign oe_n      = wr_ff || (st_ff != E_LOW); // RL1
  assign dq_oe     = wr_ff && (st_ff != E_IDLE);
  assign dq_out    = wd_ff;
  assign addr      = addr_ff;
  assign bus.rdata = rd_ff;
  assign bus.done  = (st_ff == E_DONE);

  a_we_before_ce: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    $fell(ce_n) && wr_ff |-> !we_n) else $error("write strobe not low at select");
  a_data_held: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    $rose(ce_n) && wr_ff |-> $stable(dq_out) && dq_oe) else $error("data moved at select rise");
endmodule : fes_cycle_engine

/* File: verilog/fes_host_top.sv */
// Purpose: Host sequencer for block erase with suspend, foreign read, resume
// Assumes: Device powers up in array read; status polled by re-reading
// Notes:   Each status poll is a fresh chip select pulse
`timescale 1ns/1ps
// Contract
// RL1: Suspend command halts erase; poll ready bit
// RL2: Check suspended bit before reading array
// RL3: Read array other block; resume restarts (read_addr is not checked against blk_ff)
// RL4: Device powers up in array read
// RL5: Program takes at least fifteen microseconds
// RL6: Boot or parameter erase at least 1.3s
// RL7: Main block erase at least three seconds
// RL8: Boot block relocks within 100 ns
// RL9: Latch on chip select rising edge
// RL10: Setup then confirm inside target block
module fes_host_top
  import fes_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         erase_start,
  input  wire logic [16:0]  erase_addr,
  input  wire logic         suspend_req,
  input  wire logic [16:0]  read_addr,
  input  wire logic         resume_req,
  output logic              busy,
  output logic              suspended,
  output logic              erase_done,
  output logic [7:0]        read_data,
  output logic              read_valid,
  output logic [7:0]        last_status,
  output logic              ce_n,
  output logic              oe_n,
  output logic              we_n,
  output logic [16:0]       addr,
  output logic [7:0]        dq_out,
  output logic              dq_oe,
  input  wire logic [7:0]   dq_in
);
  typedef enum logic [9:0] {
    S_IDLE   = 10'b0000000001, S_SETUP  = 10'b0000000010,
    S_CONF   = 10'b0000000100, S_POLL   = 10'b0000001000,
    S_SUSP   = 10'b0000010000, S_SPOLL  = 10'b0000100000,
    S_RDARR  = 10'b0001000000, S_READ   = 10'b0010000000,
    S_PARK   = 10'b0100000000, S_RESUME = 10'b1000000000
  } fes_st_t;

  fes_bus_if bus ();

  fes_st_t      st_ff, nxt_st;
  logic         req_ff, nxt_req;
  logic         wr_ff, nxt_wr;
  logic [16:0]  a_ff, nxt_a;
  logic [16:0]  blk_ff, nxt_blk;
  logic [7:0]   wd_ff, nxt_wd;
  logic [7:0]   stat_ff, nxt_stat;
  logic [7:0]   rdat_ff, nxt_rdat;
  logic         rv_ff, nxt_rv;
  logic         done_ff, nxt_done;
  logic         in_arr_ff, nxt_in_arr;

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff; nxt_req = 1'b0; nxt_wr = wr_ff; nxt_a = a_ff;
    nxt_blk = blk_ff; nxt_wd = wd_ff; nxt_stat = stat_ff;
    nxt_rdat = rdat_ff; nxt_rv = 1'b0; nxt_done = 1'b0;
    nxt_in_arr = in_arr_ff;
    case (st_ff)
      S_IDLE: if (erase_start) begin
        nxt_blk = erase_addr; nxt_a = erase_addr;
        nxt_wd = CMD_ERASE_SETUP; nxt_wr = 1'b1; nxt_req = 1'b1; // RL10
        nxt_in_arr = 1'b0; nxt_st = S_SETUP;
      end
      S_SETUP: if (bus.done) begin
        nxt_wd = CMD_CONFIRM; nxt_a = blk_ff; nxt_req = 1'b1; // RL10
        nxt_st = S_CONF;
      end
      S_CONF, S_RESUME: if (bus.done) begin
        nxt_wr = 1'b0; nxt_a = blk_ff; nxt_req = 1'b1;
        nxt_st = S_POLL;
      end
      // Device keeps status mode after confirm; each pulse refreshes status
      S_POLL: if (bus.done) begin
        nxt_stat = bus.rdata;
        if (bus.rdata[STATUS_READY_BIT]) begin // RL1
          nxt_done = 1'b1; nxt_st = S_IDLE;
        end else if (suspend_req) begin
          nxt_wr = 1'b1; nxt_wd = CMD_SUSPEND; nxt_req = 1'b1; // RL1
          nxt_st = S_SUSP;
        end else begin
          nxt_req = 1'b1;
        end
      end
      S_SUSP: if (bus.done) begin
        nxt_wr = 1'b0; nxt_req = 1'b1; nxt_st = S_SPOLL;
      end
      S_SPOLL: if (bus.done) begin
        nxt_stat = bus.rdata;
        if (!bus.rdata[STATUS_READY_BIT]) begin
          nxt_req = 1'b1; // RL1
        end else if (bus.rdata[STATUS_SUSPENDED_BIT]) begin
          nxt_st = S_PARK; // RL2
        end else begin
          // Erase finished before the suspend took hold
          nxt_done = 1'b1; nxt_st = S_IDLE;
        end
      end
      S_PARK: if (resume_req) begin
        nxt_wr = 1'b1; nxt_wd = CMD_CONFIRM; nxt_a = blk_ff; nxt_req = 1'b1; // RL3
        nxt_in_arr = 1'b0; nxt_st = S_RESUME;
      end else if (suspend_req) begin
        nxt_a = read_addr;
        if (in_arr_ff) begin
          nxt_wr = 1'b0; nxt_req = 1'b1; nxt_st = S_READ;
        end else begin
          nxt_wr = 1'b1; nxt_wd = CMD_READ_ARRAY; nxt_req = 1'b1; // RL3
          nxt_st = S_RDARR;
        end
      end
      S_RDARR: if (bus.done) begin
        nxt_in_arr = 1'b1; nxt_wr = 1'b0; nxt_req = 1'b1; nxt_st = S_READ;
      end
      S_READ: if (bus.done) begin
        nxt_rdat = bus.rdata; nxt_rv = 1'b1; nxt_st = S_PARK; // RL3
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= S_IDLE; req_ff <= 1'b0; wr_ff <= 1'b0; a_ff <= '0;
      blk_ff <= '0; wd_ff <= '0; stat_ff <= '0; rdat_ff <= '0;
      rv_ff <= 1'b0; done_ff <= 1'b0; in_arr_ff <= 1'b1; // RL4
    end else begin
      st_ff <= nxt_st; req_ff <= nxt_req; wr_ff <= nxt_wr; a_ff <= nxt_a;
      blk_ff <= nxt_blk; wd_ff <= nxt_wd; stat_ff <= nxt_stat;
      rdat_ff <= nxt_rdat; rv_ff <= nxt_rv; done_ff <= nxt_done;
      in_arr_ff <= nxt_in_arr;
    end
  end

  assign bus.req   = req_ff;
  assign bus.wr    = wr_ff;
  assign bus.addr  = a_ff;
  assign bus.wdata = wd_ff;

  fes_cycle_engine u_eng (
    .clk    (clk),
    .rst_n  (rst_n),
    .bus    (bus),
    .ce_n   (ce_n),
    .oe_n   (oe_n),
    .we_n   (we_n),
    .addr   (addr),
    .dq_out (dq_out),
    .dq_oe  (dq_oe),
    .dq_in  (dq_in)
  );

  assign busy        = (st_ff != S_IDLE) && (st_ff != S_PARK);
  assign suspended   = (st_ff == S_PARK) || (st_ff == S_RDARR) || (st_ff == S_READ);
  assign erase_done  = done_ff;
  assign read_data   = rdat_ff;
  assign read_valid  = rv_ff;
  assign last_status = stat_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_susp_seen;
    (st_ff == S_SPOLL) && bus.done && bus.rdata[STATUS_READY_BIT]
      && bus.rdata[STATUS_SUSPENDED_BIT];
  endsequence
  a_park_after_susp: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    s_susp_seen |=> st_ff == S_PARK) else $error("no park after suspend");
  a_read_needs_susp: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    $rose(st_ff == S_RDARR) |-> $past(st_ff) == S_PARK) else $error("array read unsuspended");
  a_resume_cmd: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    st_ff == S_RESUME && req_ff |-> wr_ff && wd_ff == CMD_CONFIRM && a_ff == blk_ff)
    else $error("bad resume command");
  a_confirm_addr: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    st_ff == S_CONF && req_ff |-> wd_ff == CMD_CONFIRM && a_ff == blk_ff)
    else $error("confirm outside block");
  a_suspend_cmd: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    st_ff == S_SUSP && req_ff |-> wr_ff && wd_ff == CMD_SUSPEND)
    else $error("bad suspend command");
  a_done_ready: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    erase_done |-> stat_ff[STATUS_READY_BIT]) else $error("done without ready");

  // Suspend and resume handshake
  sequence s_susp_issued;
    (st_ff == S_POLL) && bus.done && !bus.rdata[STATUS_READY_BIT]
      && suspend_req;
  endsequence
  a_susp_on_req: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    s_susp_issued |=> st_ff == S_SUSP && req_ff) else $error("suspend request dropped");
  a_spoll_after_susp: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    st_ff == S_SUSP && bus.done |=> st_ff == S_SPOLL && req_ff && !wr_ff)
    else $error("no status read after suspend");
  sequence s_ready_seen;
    (st_ff == S_POLL || st_ff == S_SPOLL) && bus.done && bus.rdata[STATUS_READY_BIT]
      && !bus.rdata[STATUS_SUSPENDED_BIT];
  endsequence
  a_done_on_ready: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    s_ready_seen |=> erase_done && st_ff == S_IDLE) else $error("ready without done");
  a_park_pins_idle: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    st_ff == S_PARK |-> ce_n && we_n && suspended && !busy) else $error("bus active in park");
  a_resume_on_req: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    st_ff == S_PARK && resume_req |=> st_ff == S_RESUME && req_ff) else $error("resume lost");
  // Command shapes
  a_setup_cmd: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    st_ff == S_SETUP && req_ff |-> wr_ff && wd_ff == CMD_ERASE_SETUP && a_ff == blk_ff)
    else $error("bad erase setup");
  a_poll_read: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    st_ff == S_POLL && req_ff |-> !wr_ff && a_ff == blk_ff) else $error("poll is not a read");
  a_rdarr_cmd: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    st_ff == S_RDARR && req_ff |-> wr_ff && wd_ff == CMD_READ_ARRAY)
    else $error("bad read array command");
  a_read_in_park: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    read_valid |-> st_ff == S_PARK && in_arr_ff) else $error("read outside array mode");
endmodule : fes_host_top

/* File: tb/fes_flash_model.sv */
// Purpose: Behavioural boot block flash seen from its parallel pins
// Assumes: Latches writes on chip select rise, erase time counted in clk cycles
// Notes:   Released data lines show a pattern that changes on every clock edge, twice per cycle
`timescale 1ns/1ps
module fes_flash_model #(
  parameter int ERASE_CYC = 400,
  parameter int PROG_CYC  = 150
) (
  input  wire logic        clk,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq,
  output logic             fault
);
  localparam logic [3:0] BOOT_BLK = 4'hf;
  logic       status_mode, erasing, susp, setup, psetup;
  logic [3:0] blk;
  int         remain;
  initial begin
    status_mode = 1'b0;
    erasing = 1'b0;
    susp = 1'b0;
    setup = 1'b0;
    psetup = 1'b0;
    fault = 1'b0;
    blk = 4'h0;
    remain = 0;
  end
  always @(posedge ce_n) if (!we_n) begin
    if (setup) begin
      setup = 1'b0;
      // No unlock_high_voltage reaches the model, so the boot block stays locked
      if (dq_in == 8'hd0 && addr[16:13] == blk && blk != BOOT_BLK) begin
        erasing = 1'b1;
        remain = ERASE_CYC;
        status_mode = 1'b1;
      end else fault = 1'b1;
    end else if (psetup) begin
      // Byte program keeps busy status for its whole minimum count
      psetup = 1'b0;
      erasing = 1'b1;
      remain = PROG_CYC;
      status_mode = 1'b1;
    end else case (dq_in)
      8'h20: begin setup = 1'b1; blk = addr[16:13]; end
      8'h40: psetup = 1'b1;
      8'hb0: if (erasing) begin erasing = 1'b0; susp = 1'b1; status_mode = 1'b1; end
      8'hff: status_mode = 1'b0;
      8'hd0: if (susp) begin susp = 1'b0; erasing = 1'b1; status_mode = 1'b1; end
      default: ;
    endcase
  end
  // Erase reports ready before its full count of cycles only while suspended
  always @(negedge clk) if (erasing) begin
    if (remain <= 1) erasing = 1'b0;
    else remain = remain - 1;
  end
  // Array reads from the block under erase are not allowed while suspended
  always @(posedge clk) begin
    if (!ce_n && !oe_n && !status_mode && susp && addr[16:13] == blk) fault = 1'b1;
  end
  always @* begin
    dq = {4{clk, ~clk}};
    if (!ce_n && !oe_n) dq = status_mode ? {~erasing, susp, 6'h00} : addr[7:0] ^ addr[15:8];
  end
endmodule : fes_flash_model

/* File: tb/fes_host_top_tb.sv */
// Purpose: Self-checking bench for the erase suspend host sequencer
// Assumes: Flash model answers on the pins, erase shortened to ERASE_CYC cycles
// Notes:   Expected results queued by the driver, compared by a monitor
`timescale 1ns/1ps
module fes_host_top_tb;
  import fes_pkg::*;
  localparam int ERASE_CYC = 400;
  localparam int WAIT_LIM  = 2000;
  localparam int WD_CYC    = 30000;
  logic        clk, rst_n, erase_start, suspend_req, resume_req;
  logic [16:0] erase_addr, read_addr, addr;
  logic        busy, suspended, erase_done, read_valid, ce_n, oe_n, we_n, dq_oe, fault;
  logic [7:0]  read_data, last_status, dq_out, dq_in;
  logic [7:0]  rd_q[$];
  logic [7:0]  st_q[$];
  int          n_mismatch, checked, k;
  time         t0;
  fes_host_top i_dut (.clk(clk), .rst_n(rst_n), .erase_start(erase_start),
    .erase_addr(erase_addr), .suspend_req(suspend_req), .read_addr(read_addr),
    .resume_req(resume_req), .busy(busy), .suspended(suspended), .erase_done(erase_done),
    .read_data(read_data), .read_valid(read_valid), .last_status(last_status),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in));
  fes_flash_model #(.ERASE_CYC(ERASE_CYC)) i_flash (.clk(clk), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_in(dq_out), .dq(dq_in), .fault(fault));
  always #5 clk = ~clk;
  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic stop_test();
    $display("counts: checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // Bounded wait: 0 erase done, 1 read valid, 2 suspended, 3 not busy
  task automatic wait_hi(input int w, input string msg);
    int i;
    for (i = 0; i < WAIT_LIM; i++) begin
      @(negedge clk);
      if ((w == 0 && erase_done === 1'b1) || (w == 1 && read_valid === 1'b1) ||
          (w == 2 && suspended === 1'b1) || (w == 3 && busy === 1'b0)) break;
    end
    check(i < WAIT_LIM, msg);
  endtask : wait_hi
  task automatic pulse(input int w);
    @(posedge clk);
    if (w == 0) erase_start <= 1'b1; else if (w == 1) suspend_req <= 1'b1;
    else resume_req <= 1'b1;
    @(posedge clk);
    erase_start <= 1'b0;
    suspend_req <= 1'b0;
    resume_req <= 1'b0;
  endtask : pulse
  // -------------------------------------------------------------
  // Monitor
  // -------------------------------------------------------------
  always @(negedge clk) begin
    if (read_valid === 1'b1) begin
      check(rd_q.size() > 0, "read without request");
      if (rd_q.size() > 0) check(read_data === rd_q.pop_front(), "read data");
    end
    if (erase_done === 1'b1) begin
      check(st_q.size() > 0, "done without erase");
      if (st_q.size() > 0) check((last_status & 8'hc0) === st_q.pop_front(), "status");
    end
  end
  initial begin
    #(WD_CYC * 10);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
  // -------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    erase_start = 1'b0;
    suspend_req = 1'b0;
    resume_req = 1'b0;
    erase_addr = 17'h00000;
    read_addr = 17'h00000;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'h641f1189));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    pulse(2);
    repeat (3) @(negedge clk);
    check(busy === 1'b0 && ce_n === 1'b1, "resume in idle not ignored");
    check(oe_n === 1'b1 && we_n === 1'b1 && dq_oe === 1'b0, "pins not idle");
    check(suspended === 1'b0 && erase_done === 1'b0 && read_valid === 1'b0, "flags");
    $display("test refused resume done");
    @(posedge clk);
    erase_addr <= {4'h2, 13'($urandom())};
    st_q.push_back(8'h80);
    pulse(0);
    t0 = $time;
    wait_hi(0, "erase_done missing");
    check(($time - t0) / 10 >= ERASE_CYC, "erase done too early");
    check(fault === 1'b0, "erase command sequence");
    $display("test plain erase done");
    @(posedge clk);
    erase_addr <= {4'h3, 13'($urandom())};
    // Request is still up on entry to park, so one foreign read follows at once
    read_addr <= {4'hc, 13'($urandom())};
    pulse(0);
    rd_q.push_back(read_addr[7:0] ^ read_addr[15:8]);
    @(posedge clk);
    suspend_req <= 1'b1;
    wait_hi(2, "suspend not reached");
    @(posedge clk);
    suspend_req <= 1'b0;
    wait_hi(1, "first read_valid missing");
    wait_hi(3, "park not reached");
    check(last_status[7:6] === 2'b11, "ready and suspended bits");
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      read_addr <= {4'hb ^ 4'(k), 13'($urandom())};
      @(negedge clk);
      rd_q.push_back(read_addr[7:0] ^ read_addr[15:8]);
      pulse(1);
      wait_hi(1, "read_valid missing");
      wait_hi(3, "park not reached");
    end
    check(fault === 1'b0, "read from block under erase");
    st_q.push_back(8'h80);
    pulse(2);
    wait_hi(0, "erase_done after resume missing");
    repeat (4) @(posedge clk);
    check(fault === 1'b0 && rd_q.size() == 0 && st_q.size() == 0, "resume or results");
    $display("test suspend resume done");
    stop_test();
  end
endmodule : fes_host_top_tb
